// [hw/aux_regs.sv]
module aux_regs
   import aux_regs_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   input  wire logic        dma_request,
   output logic             dma_req_n,
   input  wire logic        down_count_dec,
   input  wire logic        byte_out,
   input  wire logic        fifo_reset,
   output logic      [23:0] down_count,
   output logic             sel_timeout_load,
   output logic      [19:0] sel_timeout_value,
   output logic             upcount_readback_select,
   output logic             infinite_transfer_count,
   output logic             overrun_disconnect_enable,
   output logic             offset_load_mode,
   output logic             halt_on_parity_fault,
   input  wire logic        fifo_parity_error,
   input  wire logic        scsi_parity_error,
   input  wire logic        slave_error_in,
   input  wire logic        sync_byte_in,
   input  wire logic        offset_inc,
   input  wire logic        offset_dec,
   input  wire logic [7:0]  offset_max,
   output logic      [7:0]  offset_count,
   input  wire logic        wait_ready_enable,
   input  wire logic        script_access,
   input  wire logic        script_busy,
   input  wire logic        fifo_access,
   input  wire logic        fifo_busy,
   output logic             processor_wait_ready,
   input  wire logic        peer_connect,
   input  wire logic [2:0]  peer_id,
   input  wire logic [2:0]  own_id,
   input  wire logic        slave_mode,
   output logic             sync_mode,
   input  wire logic [3:0]  cmd_len_code,
   output logic      [4:0]  cmd_length,
   output logic             cmd_length_valid,
   input  wire logic [7:0]  scsi_data
);

   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   typedef struct packed {
      logic [4:0]  ctl;
      logic [23:0] up_cnt;
      logic [6:0]  err;
      logic [7:0]  sync_en;
      logic [2:0]  peer;
      logic        sync_mode;
      logic        toggle;
      logic        dma_req_n;
      logic [4:0]  gap_cnt;
      logic        preset;
      logic [4:0]  cmd_len;
      logic        cmd_ok;
      logic [7:0]  rdata;
   } state_t;

   state_t      s_reg;
   state_t      s_next;
   logic [23:0] down_cnt_reg;
   logic [23:0] down_cnt_next;

   offset_ctl_if ofs ();

   offset_counter u_offset (
      .clk  (clk),
      .nrst (nrst),
      .ctl  (ofs.counter)
   );

   assign ofs.inc        = offset_inc;
   assign ofs.dec        = offset_dec;
   assign ofs.max_offset = offset_max;

   // -----------------------------------------------------------------
   // Decode
   // -----------------------------------------------------------------
   logic wr_ctl;
   logic wr_sync;
   logic wr_flags_clear;

   assign wr_ctl         = reg_wr && (reg_addr == OFS_AUX_TWO);
   assign wr_sync        = reg_wr && (reg_addr == OFS_SYNC_ID);
   assign wr_flags_clear = reg_wr && (reg_addr == OFS_AUX_CTL_ONE)
                           && reg_wdata[BIT_RESET_FLAGS];

   // -----------------------------------------------------------------
   // Next state
   // -----------------------------------------------------------------
   always_comb begin
      logic [6:0]  set;
      logic [23:0] cnt_sel;
      set     = '0;
      cnt_sel = '0;
      s_next        = s_reg;
      s_next.preset = 1'b0;
      down_cnt_next = down_cnt_reg;

      // Control register; the two self-clearing bits are never stored.
      if (wr_ctl) begin
         s_next.ctl = reg_wdata[4:0];                   // [RL25]
         if (reg_wdata[BIT_DMA_TOGGLE]) begin
            s_next.toggle = ~s_reg.toggle;              // [RL1]
         end
         s_next.preset = reg_wdata[BIT_UPCOUNT_PRESET]; // [RL2] [RL25]
      end
      // The toggle inverts the request so the DMA controller sees a new edge.
      s_next.dma_req_n = ~(dma_request ^ s_reg.toggle); // [RL1]

      // Up counter: preset beats a FIFO reset, which beats counting.
      if (wr_ctl && reg_wdata[BIT_UPCOUNT_PRESET]) begin
         s_next.up_cnt = UPCOUNT_PRESET_VAL;            // [RL2]
      end else if (fifo_reset) begin
         s_next.up_cnt = '0;
      end else if (byte_out) begin
         s_next.up_cnt = s_reg.up_cnt + 24'h000001;     // [RL5]
      end

      // Down counter: a processor write beats a sequencer decrement.
      if (reg_wr && reg_addr == OFS_COUNT_LOW) begin
         down_cnt_next[7:0] = reg_wdata;                // [RL4]
      end else if (reg_wr && reg_addr == OFS_COUNT_MID) begin
         down_cnt_next[15:8] = reg_wdata;               // [RL4]
      end else if (reg_wr && reg_addr == OFS_COUNT_HIGH) begin
         down_cnt_next[23:16] = reg_wdata;              // [RL4]
      end else if (down_count_dec) begin
         down_cnt_next = down_cnt_reg - 24'h000001;     // [RL4]
      end

      // Synchronous input rate: a byte inside the minimum gap is an overrun.
      if (sync_byte_in) begin
         s_next.gap_cnt = 5'(SYNC_MIN_GAP_CYC - 1);
      end else if (s_reg.gap_cnt != 5'h00) begin
         s_next.gap_cnt = s_reg.gap_cnt - 5'h01;
      end

      // Error events.
      set[ERR_FIFO_PARITY] = fifo_parity_error;                       // [RL6]
      set[ERR_SCSI_PARITY] = scsi_parity_error;                       // [RL7]
      set[ERR_SLAVE]       = slave_error_in;                          // [RL8]
      set[ERR_SYNC_OVR]    = sync_byte_in && (s_reg.gap_cnt != 5'h00); // [RL9]
      set[ERR_OFFSET_OVR]  = ofs.overrun;                             // [RL10]
      set[ERR_SCRIPT_OVR]  = !wait_ready_enable && script_access
                             && script_busy;                          // [RL12]
      set[ERR_PROC_OVR]    = !wait_ready_enable && fifo_access
                             && fifo_busy;                            // [RL14]
      // An event in the clearing cycle is kept: the set wins.
      if (wr_flags_clear) begin
         s_next.err = set;                                            // [RL23]
      end else begin
         s_next.err = s_reg.err | set;
      end

      // Synchronous enables and connection tracking.
      if (wr_sync) begin
         s_next.sync_en = reg_wdata;                                  // [RL15]
      end
      // Enables are per bus ID only, so every unit behind an ID shares one. [RL19]
      if (slave_mode) begin
         s_next.sync_mode = s_reg.sync_en[0];                         // [RL17]
      end else if (peer_connect) begin
         s_next.peer      = peer_id;                                  // [RL16] [RL20]
         s_next.sync_mode = s_reg.sync_en[peer_id]                    // [RL16]
                            || s_reg.sync_en[own_id];                 // [RL18]
      end

      // Command length.
      s_next.cmd_len = {1'b0, cmd_len_code} + 5'h01;                  // [RL21]
      s_next.cmd_ok  = (cmd_len_code != 4'h0);                        // [RL21]

      // Read data, valid in the cycle after the strobe.
      cnt_sel = s_reg.ctl[BIT_READBACK_SEL] ? s_reg.up_cnt : down_cnt_reg; // [RL3]
      s_next.rdata = 8'h00;
      if (reg_rd) begin
         case (reg_addr)
            OFS_COUNT_LOW: begin
               s_next.rdata = cnt_sel[7:0];                           // [RL3]
            end
            OFS_COUNT_MID: begin
               s_next.rdata = cnt_sel[15:8];                          // [RL3]
            end
            OFS_COUNT_HIGH: begin
               s_next.rdata = cnt_sel[23:16];                         // [RL3]
            end
            OFS_AUX_TWO: begin
               s_next.rdata = {1'b0, s_reg.err};
            end
            OFS_SYNC_ID: begin
               s_next.rdata = {5'h00, s_reg.peer};                    // [RL20]
            end
            OFS_SNAPSHOT: begin
               s_next.rdata = scsi_data;                              // [RL22]
            end
            default: begin
               s_next.rdata = 8'h00;
            end
         endcase
      end
   end

   // -----------------------------------------------------------------
   // Registers
   // -----------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s_reg           <= '0;
         s_reg.ctl       <= CTL_RESET;
         s_reg.sync_en   <= SYNC_EN_RESET;
         s_reg.dma_req_n <= 1'b1;
         s_reg.cmd_len   <= 5'h01;
      end else begin
         s_reg <= s_next; // [RL24]
      end
   end

   // The down counter is kept across reset, so it has no reset branch.
   always_ff @(posedge clk) begin
      down_cnt_reg <= down_cnt_next; // [RL24]
   end

   // -----------------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------------
   assign reg_rdata                 = s_reg.rdata;
   assign dma_req_n                 = s_reg.dma_req_n;
   assign down_count                = down_cnt_reg;
   assign sel_timeout_load          = s_reg.preset;
   assign sel_timeout_value         = SEL_TIMEOUT_PRESET;
   assign upcount_readback_select   = s_reg.ctl[BIT_READBACK_SEL];
   assign infinite_transfer_count   = s_reg.ctl[BIT_INFINITE_TRANSFER_COUNT];
   assign overrun_disconnect_enable = s_reg.ctl[BIT_OVR_DISC];
   assign offset_load_mode          = s_reg.ctl[BIT_OFFSET_LOAD];
   assign halt_on_parity_fault      = s_reg.ctl[BIT_HALT_PARITY];
   assign offset_count              = ofs.count;
   assign sync_mode                 = s_reg.sync_mode;
   assign cmd_length                = s_reg.cmd_len;
   assign cmd_length_valid          = s_reg.cmd_ok;

   // Holding the processor off while busy rules out script and processor overruns. [RL13]
   assign processor_wait_ready = !wait_ready_enable
                                 || !((script_access && script_busy)
                                      || (fifo_access && fifo_busy));

endmodule

// [shared/aux_regs_pkg.sv]
//Contract
//RL1 - Toggle bit write flips DMA request output
//RL2 - Preset bit loads up counter, selection timeout
//RL3 - Counter select chooses up or down readback
//RL4 - Down counter: processor loaded, decremented per request
//RL5 - Up counter counts each byte leaving chip
//RL6 - Bad FIFO read parity sets flag
//RL7 - Bad SCSI receive parity sets flag
//RL8 - Slave error input sets flag; firmware clears
//RL9 - Too fast synchronous input sets overrun flag
//RL10 - Offset counter refuses out-of-range, sets flag
//RL11 - One refused offset request held, done later
//RL12 - Fast script buffer access sets overrun flag
//RL13 - Wait-ready enabled stalls processor until ready
//RL14 - Fast FIFO data access sets overrun flag
//RL15 - Eight synchronous-enable bits, one per ID
//RL16 - On connection save peer, pick sync mode
//RL17 - Slave mode uses synchronous-enable bit zero
//RL18 - Own ID bit set makes all synchronous
//RL19 - Enable bit covers all units behind ID
//RL20 - Readback returns last peer ID processed
//RL21 - Command length is code plus one
//RL22 - Snapshot read returns live SCSI data lines
//RL23 - Reset-overflow bit clears the error flags
//RL24 - Reset clears up counter, keeps down counter
//RL25 - Self-clearing bits act as one-cycle pulses
package aux_regs_pkg;

   // -----------------------------------------------------------------
   // Register offsets
   // -----------------------------------------------------------------
   localparam logic [7:0] OFS_COUNT_LOW   = 8'h10;
   localparam logic [7:0] OFS_COUNT_MID   = 8'h11;
   localparam logic [7:0] OFS_COUNT_HIGH  = 8'h12;
   localparam logic [7:0] OFS_AUX_CTL_ONE = 8'h13;
   localparam logic [7:0] OFS_AUX_TWO     = 8'h14;
   localparam logic [7:0] OFS_SYNC_ID     = 8'h15;
   localparam logic [7:0] OFS_SNAPSHOT    = 8'h16;

   // -----------------------------------------------------------------
   // Field positions
   // -----------------------------------------------------------------
   localparam int BIT_DMA_TOGGLE     = 7;
   localparam int BIT_UPCOUNT_PRESET = 5;
   localparam int BIT_READBACK_SEL   = 4;
   localparam int BIT_INFINITE_TRANSFER_COUNT         = 3;
   localparam int BIT_OVR_DISC       = 2;
   localparam int BIT_OFFSET_LOAD    = 1;
   localparam int BIT_HALT_PARITY    = 0;
   localparam int BIT_RESET_FLAGS    = 5;

   localparam int ERR_FIFO_PARITY  = 6;
   localparam int ERR_SCSI_PARITY  = 5;
   localparam int ERR_SLAVE        = 4;
   localparam int ERR_SYNC_OVR     = 3;
   localparam int ERR_OFFSET_OVR   = 2;
   localparam int ERR_SCRIPT_OVR   = 1;
   localparam int ERR_PROC_OVR     = 0;

   // -----------------------------------------------------------------
   // Reset and preset values
   // -----------------------------------------------------------------
   localparam logic [23:0] UPCOUNT_PRESET_VAL  = 24'h7ffffe;
   localparam logic [19:0] SEL_TIMEOUT_PRESET  = 20'h7fffe;
   localparam logic [4:0]  CTL_RESET           = 5'h00;
   localparam logic [7:0]  SYNC_EN_RESET       = 8'h00;

   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int CLK_PERIOD_NS     = 10;
   localparam int SYNC_MIN_GAP_NS   = 189;
   localparam int SYNC_MIN_GAP_CYC  = (SYNC_MIN_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// [shared/offset_ctl_if.sv]
interface offset_ctl_if;
   logic       inc;
   logic       dec;
   logic [7:0] max_offset;
   logic [7:0] count;
   logic       overrun;

   modport owner   (output inc, output dec, output max_offset, input count, input overrun);
   modport counter (input inc, input dec, input max_offset, output count, output overrun);
endinterface

// [hw/offset_counter.sv]
module offset_counter
   import aux_regs_pkg::*;
(
   input  wire logic   clk,
   input  wire logic   nrst,
   offset_ctl_if.counter ctl
);

   typedef struct packed {
      logic [7:0] count;
      logic       pend;
      logic       pend_up;
      logic       overrun;
   } ofs_state_t;

   ofs_state_t s_reg;
   ofs_state_t s_next;

   always_comb begin
      logic up;
      logic act;
      logic fresh;
      logic legal;
      up    = 1'b0;
      act   = 1'b0;
      fresh = 1'b0;
      legal = 1'b0;
      s_next         = s_reg;
      s_next.overrun = 1'b0;
      if (ctl.inc ^ ctl.dec) begin
         act   = 1'b1;
         fresh = 1'b1;
         up    = ctl.inc;
      end else if (!ctl.inc && s_reg.pend) begin
         act = 1'b1;
         up  = s_reg.pend_up;
      end
      legal = up ? (s_reg.count < ctl.max_offset) : (s_reg.count != 8'h00);
      if (act) begin
         if (legal) begin
            s_next.count = up ? s_reg.count + 8'h01 : s_reg.count - 8'h01;
            if (!fresh) begin
               s_next.pend = 1'b0; // [RL11]
            end
         end else if (fresh) begin
            // A refused request is not performed; it is kept for later.
            s_next.overrun = 1'b1;          // [RL10]
            s_next.pend    = 1'b1;          // [RL11]
            s_next.pend_up = up;
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign ctl.count   = s_reg.count;
   assign ctl.overrun = s_reg.overrun;

endmodule

// [testbench/aux_regs_properties.sv]
module aux_regs_properties
   import aux_regs_pkg::*;
(
   input logic        clk,
   input logic        nrst,
   input logic [7:0]  reg_addr,
   input logic [7:0]  reg_wdata,
   input logic        reg_wr,
   input logic        reg_rd,
   input logic [7:0]  reg_rdata,
   input logic        dma_request,
   input logic        dma_req_n,
   input logic        down_count_dec,
   input logic [23:0] down_count,
   input logic        sel_timeout_load,
   input logic [19:0] sel_timeout_value,
   input logic        upcount_readback_select,
   input logic        infinite_transfer_count,
   input logic        overrun_disconnect_enable,
   input logic        offset_load_mode,
   input logic        halt_on_parity_fault,
   input logic        slave_error_in,
   input logic        offset_inc,
   input logic        offset_dec,
   input logic [7:0]  offset_max,
   input logic [7:0]  offset_count,
   input logic [3:0]  cmd_len_code,
   input logic [4:0]  cmd_length,
   input logic        cmd_length_valid,
   input logic [7:0]  scsi_data
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   logic wr_ctl;
   logic wr_tog;
   assign wr_ctl = reg_wr && reg_addr == OFS_AUX_TWO;
   assign wr_tog = wr_ctl && reg_wdata[BIT_DMA_TOGGLE];
   // -----------------------------------------------------------------
   // Properties
   // -----------------------------------------------------------------
   // The request level is held steady around the write so only the toggle can move the pin.
   property p_dma_toggle;
      wr_tog && !$past(wr_tog) && $stable(dma_request) ##1 !wr_tog && $stable(dma_request)
         |-> ##1 dma_req_n != $past(dma_req_n, 2);
   endproperty
   property p_preset;
      wr_ctl && reg_wdata[BIT_UPCOUNT_PRESET] |=> sel_timeout_load
         && sel_timeout_value == SEL_TIMEOUT_PRESET;
   endproperty
   property p_preset_pulse;
      sel_timeout_load |-> $past(wr_ctl && reg_wdata[BIT_UPCOUNT_PRESET]);
   endproperty
   property p_ctl_levels;
      wr_ctl |=> {upcount_readback_select, infinite_transfer_count, overrun_disconnect_enable,
                  offset_load_mode, halt_on_parity_fault} == $past(reg_wdata[4:0]);
   endproperty
   property p_down_dec;
      down_count_dec && !reg_wr |=> down_count == $past(down_count) - 24'h000001;
   endproperty
   property p_slave_flag;
      slave_error_in ##1 !reg_wr ##1 (reg_rd && reg_addr == OFS_AUX_TWO)
         |=> reg_rdata[ERR_SLAVE];
   endproperty
   property p_offset_refuse;
      offset_inc && !offset_dec && offset_count >= offset_max |=> $stable(offset_count);
   endproperty
   property p_cmd_len;
      $past(nrst) |-> cmd_length == 5'($past(cmd_len_code)) + 5'h01
         && cmd_length_valid == ($past(cmd_len_code) != 4'h0);
   endproperty
   property p_snapshot;
      reg_rd && reg_addr == OFS_SNAPSHOT |=> reg_rdata == $past(scsi_data);
   endproperty
   a_dma_toggle: assert property (p_dma_toggle) else $error("dma request did not flip");
   a_preset: assert property (p_preset) else $error("preset not loaded");
   a_preset_pulse: assert property (p_preset_pulse) else $error("stray preset pulse");
   a_ctl_levels: assert property (p_ctl_levels) else $error("control bits wrong");
   a_down_dec: assert property (p_down_dec) else $error("down count step wrong");
   a_slave_flag: assert property (p_slave_flag) else $error("slave flag missing");
   a_offset_refuse: assert property (p_offset_refuse) else $error("offset moved");
   a_cmd_len: assert property (p_cmd_len) else $error("command length wrong");
   a_snapshot: assert property (p_snapshot) else $error("snapshot wrong");
   c_toggle: cover property (wr_tog);
   c_refuse: cover property (offset_inc && offset_count >= offset_max);
   c_slave: cover property (p_slave_flag);
endmodule

bind aux_regs aux_regs_properties i_props (
   .clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .dma_request,
   .dma_req_n, .down_count_dec, .down_count, .sel_timeout_load, .sel_timeout_value,
   .upcount_readback_select, .infinite_transfer_count, .overrun_disconnect_enable,
   .offset_load_mode, .halt_on_parity_fault, .slave_error_in, .offset_inc, .offset_dec,
   .offset_max, .offset_count, .cmd_len_code, .cmd_length, .cmd_length_valid, .scsi_data
);

// [testbench/dma_ctl_model.sv]
module dma_ctl_model (
   input  logic       clk,
   input  logic       nrst,
   input  logic       dma_req_n,
   output logic [7:0] req_edges
);
   timeunit 1ns;
   timeprecision 1ns;
   logic last_req_n;
   // An edge-sensitive controller wakes only on a fresh falling edge.
   // A request held low without a new edge leaves it idle, which is the hang to escape.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         last_req_n <= 1'b1;
         req_edges  <= 8'h00;
      end else begin
         last_req_n <= dma_req_n;
         if (last_req_n && !dma_req_n) begin
            req_edges <= req_edges + 8'h01;
         end
      end
   end
endmodule

// [testbench/aux_regs_tb.sv]
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin fail_count++; \
   $display("[ERR] %s expected %h seen %h", nm, exp, got); end end
module aux_regs_tb
   import aux_regs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk, nrst, reg_wr, reg_rd, dma_request, dma_req_n, sync_mode;
   logic        wait_ready_enable, script_busy, fifo_busy, slave_mode, cmd_length_valid;
   logic        processor_wait_ready;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, offset_max, offset_count, scsi_data, edges, d;
   logic [2:0]  peer_id, own_id;
   logic [3:0]  cmd_len_code;
   logic [4:0]  cmd_length;
   logic [11:0] ev;
   logic [23:0] down_count, v;
   int          fail_count, n_checks, cyc;
   aux_regs i_dut (
      .clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .dma_request,
      .dma_req_n, .down_count_dec(ev[9]), .byte_out(ev[8]), .fifo_reset(ev[10]), .down_count,
      .sel_timeout_load(), .sel_timeout_value(), .upcount_readback_select(),
      .infinite_transfer_count(), .overrun_disconnect_enable(), .offset_load_mode(),
      .halt_on_parity_fault(), .fifo_parity_error(ev[0]), .scsi_parity_error(ev[1]),
      .slave_error_in(ev[2]), .sync_byte_in(ev[3]), .offset_inc(ev[4]), .offset_dec(ev[5]),
      .offset_max, .offset_count, .wait_ready_enable, .script_access(ev[6]), .script_busy,
      .fifo_access(ev[7]), .fifo_busy, .processor_wait_ready, .peer_connect(ev[11]),
      .peer_id, .own_id, .slave_mode, .sync_mode, .cmd_len_code, .cmd_length,
      .cmd_length_valid, .scsi_data
   );
   dma_ctl_model i_dma (.clk, .nrst, .dma_req_n, .req_edges(edges));
   // -----------------------------------------------------------------
   // Bus tasks
   // -----------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [7:0] dat);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= dat;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] dat);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 dat = reg_rdata;
   endtask
   task automatic rd3(output logic [23:0] val);
      logic [7:0] b0, b1, b2;
      rd(OFS_COUNT_LOW, b0);
      rd(OFS_COUNT_MID, b1);
      rd(OFS_COUNT_HIGH, b2);
      val = {b2, b1, b0};
   endtask
   task automatic pulse(input logic [11:0] m);
      @(posedge clk);
      ev <= m;
      @(posedge clk);
      ev <= '0;
   endtask
   task automatic settle;
      repeat (2) @(posedge clk);
      #1;
   endtask
   task automatic conn(input logic [2:0] p, input logic [2:0] o, input logic e);
      @(posedge clk);
      peer_id <= p;
      own_id  <= o;
      pulse(12'h800);
      settle();
      `CHK("sync_mode", e, sync_mode)
   endtask
   task automatic summarize;
      if (fail_count == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // -----------------------------------------------------------------
   // Clock and time limit
   // -----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 4000) begin
         fail_count++;
         summarize();
      end
   end
   // -----------------------------------------------------------------
   // Test sequence
   // -----------------------------------------------------------------
   initial begin
      static logic [11:0] m[6] = '{12'h001, 12'h002, 12'h004, 12'h008, 12'h040, 12'h080};
      static logic [7:0]  f[6] = '{8'h40, 8'h20, 8'h10, 8'h08, 8'h02, 8'h01};
      logic [7:0]  e;
      logic        b;
      {nrst, reg_wr, reg_rd, reg_addr, reg_wdata, ev, peer_id, own_id, slave_mode} = '0;
      {wait_ready_enable, cmd_len_code} = '0;
      {dma_request, script_busy, fifo_busy} = 3'b111;
      offset_max = 8'h02;
      scsi_data  = 8'ha5;
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      rd(OFS_AUX_TWO, d);
      `CHK("flags", 8'h00, d)
      rd(8'h30, d);
      `CHK("unmapped", 8'h00, d)
      wr(OFS_COUNT_LOW, 8'h03);
      wr(OFS_COUNT_MID, 8'h02);
      wr(OFS_COUNT_HIGH, 8'h01);
      repeat (3) pulse(12'h200);
      wr(OFS_AUX_TWO, 8'h00);
      rd3(v);
      `CHK("down", 24'h010200, v)
      repeat (2) pulse(12'h100);
      wr(OFS_AUX_TWO, 8'h10);
      rd3(v);
      `CHK("up", 24'h000002, v)
      @(posedge clk);
      nrst <= 1'b0;
      @(posedge clk);
      nrst <= 1'b1;
      wr(OFS_AUX_TWO, 8'h1f);
      rd3(v);
      `CHK("up", 24'h000000, v)
      `CHK("down", 24'h010200, down_count)
      wr(OFS_AUX_TWO, 8'h30);
      rd3(v);
      `CHK("up", UPCOUNT_PRESET_VAL, v)
      b = dma_req_n;
      e = edges;
      wr(OFS_AUX_TWO, 8'h80);
      settle();
      `CHK("dma_req_n", ~b, dma_req_n)
      wr(OFS_AUX_TWO, 8'h80);
      settle();
      `CHK("dma edges", e + 8'h01, edges)
      @(posedge clk);
      dma_request <= 1'b0;
      settle();
      `CHK("dma_req_n", 1'b1, dma_req_n)
      @(posedge clk);
      dma_request <= 1'b1;
      repeat (3) pulse(12'h010);
      settle();
      `CHK("offset", 8'h02, offset_count)
      pulse(12'h020);
      settle();
      `CHK("offset", 8'h02, offset_count)
      repeat (2) pulse(12'h020);
      rd(OFS_AUX_TWO, d);
      `CHK("flags", 8'h04, d)
      e = 8'h04;
      for (int i = 0; i < 6; i++) begin
         pulse(m[i]);
         pulse(m[i]);
         e = e | f[i];
         rd(OFS_AUX_TWO, d);
         `CHK("flags", e, d)
      end
      wr(OFS_AUX_CTL_ONE, 8'h20);
      rd(OFS_AUX_TWO, d);
      `CHK("flags", 8'h00, d)
      @(posedge clk);
      wait_ready_enable <= 1'b1;
      @(posedge clk);
      ev <= 12'h0c0;
      #1;
      `CHK("wait_ready", 1'b0, processor_wait_ready)
      @(posedge clk);
      ev <= '0;
      rd(OFS_AUX_TWO, d);
      `CHK("flags", 8'h00, d)
      wr(OFS_SYNC_ID, 8'h08);
      conn(3'd3, 3'd0, 1'b1);
      rd(OFS_SYNC_ID, d);
      `CHK("peer", 8'h03, d)
      conn(3'd2, 3'd3, 1'b1);
      conn(3'd2, 3'd0, 1'b0);
      wr(OFS_SYNC_ID, 8'h01);
      slave_mode <= 1'b1;
      settle();
      `CHK("sync_mode", 1'b1, sync_mode)
      for (int c = 0; c < 16; c++) begin
         @(posedge clk);
         cmd_len_code <= 4'(c);
         settle();
         `CHK("cmd_length", 5'(c + 1), cmd_length)
         `CHK("cmd_valid", c != 0, cmd_length_valid)
      end
      rd(OFS_SNAPSHOT, d);
      `CHK("snapshot", 8'ha5, d)
      @(posedge clk);
      scsi_data <= 8'h5a;
      rd(OFS_SNAPSHOT, d);
      `CHK("snapshot", 8'h5a, d)
      summarize();
   end
endmodule
